// File: inc/uhri_pkg.sv
// constants and types for the uart holding and interrupt mask block
// How it works
// - a holding write pushes data bus bits 7..0 as one character
// - holding-empty status bit reads 1 while the transmit buffer is empty
// - a receive holding read returns the oldest character and drops it
// - line fall while idle starts a count, sampled 7.5 sample clocks later
// - start accepted only if mid sample is low, else edge discarded
// - each source reaches the interrupt only while its mask bit is set
// - each channel has its own interrupt output pin
// - mask bit 7 raises an interrupt on clear-to-send rising
// - mask bit 6 raises an interrupt on request-to-send rising
// - mask bit 5 raises an interrupt on a received Xoff
// - mask bit 4 is the sleep mode enable
// - mask bit 3 interrupts while any modem change bit is set
// - mask bit 2 interrupts while any receive error bit is set
// - mask bit 1 tracks empty status, or transmit-empty event with FIFOs
// - transmit-empty interrupt reports at level three
// - no FIFOs: receive interrupt follows holding register data presence
// - FIFOs on: receive interrupt while count is at or above trigger
// - receive-ready interrupt reports at level two
// - all mask bits reset to zero
// - mask bits 7..4 writable only while enhanced enable bit is set
// - with FIFOs on, transmit-empty interrupt clears on identify read or holding write
package uhri_pkg;
    localparam logic [2:0] A_DATA  = 3'h0;
    localparam logic [2:0] A_IMASK = 3'h1;
    localparam logic [2:0] A_IDENT = 3'h2;
    localparam logic [2:0] A_LCR   = 3'h3;
    localparam logic [2:0] A_MCR   = 3'h4;
    localparam logic [2:0] A_LSTAT = 3'h5;
    localparam logic [2:0] A_MSTAT = 3'h6;
    localparam logic [7:0] ENH_KEY = 8'hBF;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int         ENH_EN  = 4;
    localparam int         IM_SLP  = 4;
    localparam int         MCR_RTS = 1;
    localparam int         FCR_EN  = 0;
    localparam int         FCR_TRG = 6;
    localparam logic [2:0] LVL_LS  = 3'h1;
    localparam logic [2:0] LVL_RX  = 3'h2;
    localparam logic [2:0] LVL_TX  = 3'h3;
    localparam logic [2:0] LVL_MS  = 3'h4;
    localparam int         HALVES  = 15;
    typedef enum logic {S_IDLE = 1'b0, S_CHECK = 1'b1} uhri_start_t;
    typedef struct packed {
        logic [7:0]  imask;
        logic [7:0]  lcr;
        logic [7:0]  enh;
        logic [7:0]  fcr;
        logic [7:0]  mcr;
        logic [7:0]  txb0;
        logic [7:0]  txb1;
        logic [1:0]  txn;
        logic [7:0]  rxb0;
        logic [7:0]  rxb1;
        logic [1:0]  rxn;
        logic [3:0]  lerr;
        logic [3:0]  mchg;
        logic        xoff_f;
        logic        rts_f;
        logic        cts_f;
        logic        thre_f;
        logic [7:0]  rdata;
        logic        cts1;
        logic        cts2;
        logic        cts_q;
        logic        rts_q;
        logic        ln1;
        logic        ln2;
        logic        ln_q;
        uhri_start_t st;
        logic [15:0] cnt;
        logic        ok;
        logic        bad;
    } uhri_ch_t;
    typedef struct packed {
        logic       csa1, csa2, csb1, csb2;
        logic       rd1, rd2, rd_q, wr1, wr2, wr_q;
        logic [2:0] ad1, ad2;
        logic [7:0] d1, d2;
    } uhri_bus_t;
endpackage

// File: design/uhri_top.sv
// two-channel uart holding registers, start validator and interrupt masking
`timescale 1ns/1ps
module uhri_chan import uhri_pkg::*; #(
    parameter int SAMPLE_DIV = 2
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // synchronised host strobes
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    // transmit side toward the shifter
    output logic      [7:0] o_tx_data,
    output logic            o_tx_valid,
    input  wire logic       i_tx_ready,
    output logic            o_tx_space_avail,
    // receive side from the shifter
    input  wire logic [7:0] i_rx_data,
    input  wire logic       i_rx_valid,
    output logic            o_rx_ready,
    output logic            o_rx_data_avail,
    input  wire logic [3:0] i_rx_err,
    // line, modem and flow events
    input  wire logic       i_rx_line,
    output logic            o_start_ok,
    output logic            o_start_bad,
    input  wire logic       i_clear_to_send_in,
    output logic            o_request_to_send_out,
    input  wire logic [2:0] i_modem_chg,
    input  wire logic       i_xoff_rcvd,
    output logic            o_sleep_en,
    output logic            o_irq
);
    localparam int HALF_CYC = (HALVES * SAMPLE_DIV) / 2;
    // elaboration check: the half-bit count rides on an even divider
    if (SAMPLE_DIV < 2 || SAMPLE_DIV % 2 != 0 || HALF_CYC > 65535) begin : g_bad_div
        $error("SAMPLE_DIV must be even, at least 2");
    end

    uhri_ch_t r;
    uhri_ch_t next_r;
    logic     push_tx, pop_tx, push_rx, pop_rx, thre_set, ident_rd;
    logic     fifo_on, src_rx, src_tx, cts_rise;
    logic [1:0] trig;
    logic [7:0] src;
    logic [2:0] lvl;

    // sources and level, all from registered state
    always_comb begin
        fifo_on  = r.fcr[FCR_EN];
        trig     = (r.fcr[FCR_TRG+1 -: 2] == 2'h0) ? 2'h1 : 2'h2;
        src_rx   = fifo_on ? (r.rxn >= trig) : (r.rxn != 2'h0);
        src_tx   = fifo_on ? r.thre_f : (r.txn == 2'h0);
        cts_rise = r.cts2 & ~r.cts_q;
        src      = {r.cts_f, r.rts_f, r.xoff_f, 1'b0, |r.mchg, |r.lerr, src_tx, src_rx};
        if (|(src[2] & r.imask[2]))
            lvl = LVL_LS;
        else if (src[0] & r.imask[0])
            lvl = LVL_RX;
        else if (src[1] & r.imask[1])
            lvl = LVL_TX;
        else
            lvl = LVL_MS;
    end

    // one interrupt pin per channel instance
    assign o_irq            = |(src & r.imask);
    assign o_sleep_en       = r.imask[IM_SLP];
    assign o_rdata          = r.rdata;
    assign o_tx_data        = r.txb0;
    assign o_tx_valid       = r.txn != 2'h0;
    assign o_tx_space_avail = r.txn != 2'h2;
    assign o_rx_ready       = r.rxn != 2'h2; // stall keeps words in shifter
    assign o_rx_data_avail  = r.rxn != 2'h0;
    assign o_start_ok       = r.ok;
    assign o_start_bad      = r.bad;
    assign o_request_to_send_out = r.mcr[MCR_RTS];

    // register file, buffers, flags and start validator
    always_comb begin
        next_r   = r;
        push_tx  = i_wr && i_addr == A_DATA && r.txn != 2'h2;
        pop_tx   = i_tx_ready && r.txn != 2'h0;
        push_rx  = i_rx_valid && r.rxn != 2'h2;
        pop_rx   = i_rd && i_addr == A_DATA && r.rxn != 2'h0;
        ident_rd = i_rd && i_addr == A_IDENT && r.lcr != ENH_KEY;
        thre_set = r.txn != 2'h0 && pop_tx && !push_tx && r.txn == 2'h1;
        // transmit buffer: pop shifts, push fills next free slot
        if (pop_tx) begin
            next_r.txb0 = r.txb1;
        end
        if (push_tx) begin
            if (r.txn == 2'h0 || (r.txn == 2'h1 && pop_tx))
                next_r.txb0 = i_wdata;
            else
                next_r.txb1 = i_wdata;
        end
        next_r.txn = r.txn + {1'b0, push_tx} - {1'b0, pop_tx};
        // receive buffer, oldest word always in slot 0
        if (pop_rx) begin
            next_r.rxb0 = r.rxb1;
        end
        if (push_rx) begin
            if (r.rxn == 2'h0 || (r.rxn == 2'h1 && pop_rx))
                next_r.rxb0 = i_rx_data;
            else
                next_r.rxb1 = i_rx_data;
        end
        next_r.rxn = r.rxn + {1'b0, push_rx} - {1'b0, pop_rx};
        // host writes
        if (i_wr) begin
            unique case (i_addr)
                A_IMASK: begin
                    next_r.imask[3:0] = i_wdata[3:0];
                    if (r.enh[ENH_EN])
                        next_r.imask[7:4] = i_wdata[7:4];
                end
                A_IDENT: begin
                    if (r.lcr == ENH_KEY)
                        next_r.enh = i_wdata;
                    else
                        next_r.fcr = i_wdata;
                end
                A_LCR:   next_r.lcr = i_wdata;
                A_MCR:   next_r.mcr = i_wdata;
                default: ;
            endcase
        end
        // host reads: latch data, then apply read side effects
        if (i_rd) begin
            unique case (i_addr)
                A_DATA:  next_r.rdata = r.rxb0;
                A_IMASK: next_r.rdata = r.imask;
                A_IDENT: next_r.rdata = (r.lcr == ENH_KEY) ? r.enh :
                                        {4'h0, lvl, ~o_irq};
                A_LCR:   next_r.rdata = r.lcr;
                A_MCR:   next_r.rdata = r.mcr;
                A_LSTAT: next_r.rdata = {|r.lerr, r.txn == 2'h0, r.txn == 2'h0,
                                         r.lerr, r.rxn != 2'h0};
                A_MSTAT: next_r.rdata = {3'h0, r.cts2, r.mchg};
                default: next_r.rdata = REG_RST;
            endcase
        end
        // sticky flags: clears first, so a same-cycle set wins
        if (i_rd && i_addr == A_LSTAT)
            next_r.lerr = 4'h0;
        if (i_rd && i_addr == A_MSTAT)
            next_r.mchg = 4'h0;
        if (ident_rd) begin
            next_r.xoff_f = 1'b0;
            next_r.rts_f  = 1'b0;
            next_r.cts_f  = 1'b0;
        end
        if (ident_rd || push_tx)
            next_r.thre_f = 1'b0;
        next_r.lerr = next_r.lerr | i_rx_err;
        next_r.mchg = next_r.mchg | {i_modem_chg, r.cts2 ^ r.cts_q};
        if (thre_set)
            next_r.thre_f = 1'b1;
        if (i_xoff_rcvd)
            next_r.xoff_f = 1'b1;
        if (r.mcr[MCR_RTS] && !r.rts_q)
            next_r.rts_f = 1'b1;
        if (cts_rise)
            next_r.cts_f = 1'b1;
        // pin synchronisers; logic reads stage 2, and stage 3 only for edge detection
        next_r.cts1  = i_clear_to_send_in;
        next_r.cts2  = r.cts1;
        next_r.cts_q = r.cts2;
        next_r.rts_q = r.mcr[MCR_RTS];
        next_r.ln1   = i_rx_line;
        next_r.ln2   = r.ln1;
        next_r.ln_q  = r.ln2;
        // start validator: half cycle timing rides on the even divider
        next_r.ok  = 1'b0;
        next_r.bad = 1'b0;
        unique case (r.st)
            S_IDLE: begin
                if (r.ln_q && !r.ln2) begin
                    next_r.st  = S_CHECK;
                    next_r.cnt = 16'h0001;
                end
            end
            S_CHECK: begin
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt == HALF_CYC[15:0]) begin
                    next_r.st  = S_IDLE;
                    next_r.ok  = !r.ln2;
                    next_r.bad = r.ln2;
                end
            end
        endcase
    end

    // single state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
            r.ln1 <= 1'b1;
            r.ln2 <= 1'b1;
            r.ln_q <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    a_lstat_empty: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == A_LSTAT) |=> r.rdata[5] == $past(r.txn == 2'h0))
        else $error("empty status bit wrong");
    a_rx_oldest: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (pop_rx && !push_rx) |=> r.rdata == $past(r.rxb0) && r.rxn == $past(r.rxn) - 2'h1)
        else $error("receive read not oldest");
    a_start_enter: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (r.st == S_IDLE && r.ln_q && !r.ln2) |=> r.st == S_CHECK ##(HALF_CYC - 1) r.st == S_CHECK)
        else $error("start count wrong");
    a_start_mid: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (r.st == S_CHECK && r.cnt == HALF_CYC[15:0]) |=> r.ok == !$past(r.ln2) && r.bad != r.ok)
        else $error("mid sample verdict wrong");
    a_mask_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (r.imask == 8'h00) |-> !o_irq)
        else $error("interrupt with all masked");
    a_cts_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cts_rise && r.imask[7] && !(i_wr && i_addr == A_IMASK)) |=> o_irq)
        else $error("clear-to-send interrupt lost");
    a_upper_lock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == A_IMASK && !r.enh[ENH_EN]) |=> r.imask[7:4] == $past(r.imask[7:4]))
        else $error("upper mask bits changed while locked");
    a_thre_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (push_tx && !thre_set) |=> !r.thre_f)
        else $error("transmit empty not cleared by write");
    a_rx_trigger: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (fifo_on && r.imask[0] && r.rxn >= trig) |-> o_irq)
        else $error("receive trigger interrupt missing");
    a_rx_below: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (fifo_on && r.imask == 8'h01 && r.rxn < trig) |-> !o_irq)
        else $error("receive interrupt below trigger");
endmodule

module uhri_top import uhri_pkg::*; #(
    parameter int SAMPLE_DIV = 2
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // host parallel bus pins
    input  wire logic       i_cs_a_n,
    input  wire logic       i_cs_b_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic            o_data_oe,
    // per-channel shifter side, index 0 is channel a
    output logic [1:0][7:0] o_tx_data,
    output logic      [1:0] o_tx_valid,
    input  wire logic [1:0] i_tx_ready,
    output logic      [1:0] o_tx_space_avail,
    input  wire logic [1:0][7:0] i_rx_data,
    input  wire logic [1:0] i_rx_valid,
    output logic      [1:0] o_rx_ready,
    output logic      [1:0] o_rx_data_avail,
    input  wire logic [1:0][3:0] i_rx_err,
    // per-channel pins and events
    input  wire logic [1:0] i_rx_line,
    output logic      [1:0] o_start_ok,
    output logic      [1:0] o_start_bad,
    input  wire logic [1:0] i_clear_to_send_in,
    output logic      [1:0] o_request_to_send_out,
    input  wire logic [1:0][2:0] i_modem_chg,
    input  wire logic [1:0] i_xoff_rcvd,
    output logic      [1:0] o_sleep_en,
    output logic            o_irq_out_ch_a,
    output logic            o_irq_out_ch_b
);
    uhri_bus_t       b;
    uhri_bus_t       next_b;
    logic            wr_p, rd_p;
    logic [1:0]      sel;
    logic [1:0][7:0] rdat;
    logic [1:0]      irq;

    // strobes act on their edges after two-stage pin sync
    assign wr_p = b.wr2 & ~b.wr_q;
    assign rd_p = ~b.rd2 & b.rd_q;
    assign sel  = {~b.csb2, ~b.csa2};
    assign o_data    = sel[1] ? rdat[1] : rdat[0];
    assign o_data_oe = ~b.rd2 & (|sel);
    assign o_irq_out_ch_a = irq[0];
    assign o_irq_out_ch_b = irq[1];

    // pin synchronisers
    always_comb begin
        next_b      = b;
        next_b.csa1 = i_cs_a_n;
        next_b.csa2 = b.csa1;
        next_b.csb1 = i_cs_b_n;
        next_b.csb2 = b.csb1;
        next_b.rd1  = i_rd_n;
        next_b.rd2  = b.rd1;
        next_b.rd_q = b.rd2;
        next_b.wr1  = i_wr_n;
        next_b.wr2  = b.wr1;
        next_b.wr_q = b.wr2;
        next_b.ad1  = i_addr;
        next_b.ad2  = b.ad1;
        next_b.d1   = i_data;
        next_b.d2   = b.d1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            b <= '1;
        else
            b <= next_b;
    end

    // independent channel copies
    for (genvar c = 0; c < 2; c++) begin : g_ch
        uhri_chan #(.SAMPLE_DIV(SAMPLE_DIV)) u_ch (
            .i_clk                 (i_clk),
            .i_rst_n               (i_rst_n),
            .i_wr                  (wr_p & sel[c]),
            .i_rd                  (rd_p & sel[c]),
            .i_addr                (b.ad2),
            .i_wdata               (b.d2),
            .o_rdata               (rdat[c]),
            .o_tx_data             (o_tx_data[c]),
            .o_tx_valid            (o_tx_valid[c]),
            .i_tx_ready            (i_tx_ready[c]),
            .o_tx_space_avail      (o_tx_space_avail[c]),
            .i_rx_data             (i_rx_data[c]),
            .i_rx_valid            (i_rx_valid[c]),
            .o_rx_ready            (o_rx_ready[c]),
            .o_rx_data_avail       (o_rx_data_avail[c]),
            .i_rx_err              (i_rx_err[c]),
            .i_rx_line             (i_rx_line[c]),
            .o_start_ok            (o_start_ok[c]),
            .o_start_bad           (o_start_bad[c]),
            .i_clear_to_send_in    (i_clear_to_send_in[c]),
            .o_request_to_send_out (o_request_to_send_out[c]),
            .i_modem_chg           (i_modem_chg[c]),
            .i_xoff_rcvd           (i_xoff_rcvd[c]),
            .o_sleep_en            (o_sleep_en[c]),
            .o_irq                 (irq[c])
        );
    end
endmodule

// File: dv/uhri_shift_model.sv
// shifter-side partner: drains transmit characters and offers receive ones
`timescale 1ns/1ps
module uhri_shift_model (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // bench controls
    input  wire logic       i_stall,
    input  wire logic       i_send,
    input  wire logic [7:0] i_char,
    // transmit sink
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_valid,
    output logic            o_tx_ready,
    output logic            o_got,
    output logic      [7:0] o_got_data,
    // receive source
    output logic      [7:0] o_rx_data,
    output logic            o_rx_valid,
    input  wire logic       i_rx_ready
);
    // sink: a stall holds ready low, so the buffer must keep its words
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_ready <= 1'b0;
            o_got      <= 1'b0;
            o_got_data <= 8'h00;
        end else begin
            o_tx_ready <= !i_stall;
            o_got      <= i_tx_valid && o_tx_ready;
            o_got_data <= i_tx_data;
        end
    end
    // source: valid and data held until taken, then data scrambled
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_valid <= 1'b0;
            o_rx_data  <= 8'h00;
        end else if (o_rx_valid && i_rx_ready) begin
            o_rx_valid <= 1'b0;
            o_rx_data  <= ~o_rx_data;
        end else if (i_send && !o_rx_valid) begin
            o_rx_valid <= 1'b1;
            o_rx_data  <= i_char;
        end
    end
endmodule

// File: dv/testbench.sv
// self-checking bench for the two-channel holding and interrupt mask block
`timescale 1ns/1ps
module testbench import uhri_pkg::*;;
    logic            clk, rst_n, rd_n, wr_n, oe, irq_a, irq_b;
    logic      [1:0] cs_n, stall, send, rx_line, cts, xoff, space, avail, s_ok, s_bad;
    logic      [1:0] tx_valid, rx_ready, rts, sleep;
    wire       [1:0] tx_ready, rx_valid, got;
    wire  [1:0][7:0] rx_data, got_data;
    logic      [2:0] addr;
    logic      [7:0] wdata, rdata;
    logic [1:0][7:0] tx_data, chr;
    logic [1:0][3:0] err;
    logic [1:0][2:0] mchg;
    logic      [7:0] txq[$], rxq[$];
    logic      [7:0] ev_mask[5] = '{8'h04, 8'h08, 8'h20, 8'h40, 8'h80};
    logic      [7:0] ev_id[5]   = '{8'h02, 8'h08, 8'h08, 8'h08, 8'h08};
    int              errors     = 0;
    int              n_compared = 0;

    always #5 clk = ~clk;

    uhri_top #(.SAMPLE_DIV(2)) dut_u (
        .i_clk(clk), .i_rst_n(rst_n), .i_cs_a_n(cs_n[0]), .i_cs_b_n(cs_n[1]),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .i_data(wdata), .o_data(rdata),
        .o_data_oe(oe), .o_tx_data(tx_data), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
        .o_tx_space_avail(space), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
        .o_rx_ready(rx_ready), .o_rx_data_avail(avail), .i_rx_err(err), .i_rx_line(rx_line),
        .o_start_ok(s_ok), .o_start_bad(s_bad), .i_clear_to_send_in(cts),
        .o_request_to_send_out(rts), .i_modem_chg(mchg), .i_xoff_rcvd(xoff),
        .o_sleep_en(sleep), .o_irq_out_ch_a(irq_a), .o_irq_out_ch_b(irq_b)
    );

    // one shifter partner per channel
    for (genvar g = 0; g < 2; g++) begin : g_sh
        uhri_shift_model sh_u (
            .i_clk(clk), .i_rst_n(rst_n), .i_stall(stall[g]), .i_send(send[g]),
            .i_char(chr[g]), .i_tx_data(tx_data[g]), .i_tx_valid(tx_valid[g]),
            .o_tx_ready(tx_ready[g]), .o_got(got[g]), .o_got_data(got_data[g]),
            .o_rx_data(rx_data[g]), .o_rx_valid(rx_valid[g]), .i_rx_ready(rx_ready[g])
        );
    end

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // strobes are asynchronous pins, so each phase spans several clocks
    task automatic bus_wr(input int ch, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        cs_n[ch] = 1'b0;
        addr = a;
        wdata = d;
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        @(negedge clk);
        cs_n = 2'h3;
        repeat (3) @(negedge clk);
    endtask

    task automatic rd_chk(input int ch, input logic [2:0] a, input logic [7:0] e);
        @(negedge clk);
        cs_n[ch] = 1'b0;
        addr = a;
        rd_n = 1'b0;
        repeat (6) @(negedge clk);
        chk_bit("read enable", 1'b1, oe);
        chk_byte("read data", e, rdata);
        rd_n = 1'b1;
        @(negedge clk);
        cs_n = 2'h3;
        repeat (3) @(negedge clk);
    endtask

    task automatic send_rx(input int ch, input logic [7:0] c);
        for (int i = 0; i < 200 && rx_valid[ch] === 1'b1; i++) @(negedge clk);
        chr[ch] = c;
        send[ch] = 1'b1;
        @(negedge clk);
        send[ch] = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    task automatic fire(input int k);
        @(negedge clk);
        case (k)
            0: err[0] = 4'h2;
            1: mchg[0] = 3'h1;
            2: xoff[0] = 1'b1;
            3: bus_wr(0, A_MCR, 8'h02);
            default: cts[0] = 1'b1;
        endcase
        @(negedge clk);
        {err, mchg, xoff} = '0;
        repeat (4) @(negedge clk);
    endtask

    // line falls; verdict pulse expected near 15 clocks plus sync later
    task automatic start_try(input int ch, input int lo, input logic good);
        int t_ok;
        int t_bad;
        t_ok = -1;
        t_bad = -1;
        @(negedge clk);
        rx_line[ch] = 1'b0;
        for (int i = 1; i <= 30; i++) begin
            @(negedge clk);
            if (i == lo) rx_line[ch] = 1'b1;
            if (s_ok[ch] === 1'b1) t_ok = i;
            if (s_bad[ch] === 1'b1) t_bad = i;
        end
        rx_line[ch] = 1'b1;
        chk_bit("start ok", good, t_ok >= 16 && t_ok <= 21);
        chk_bit("start bad", !good, t_bad >= 16 && t_bad <= 21);
        repeat (4) @(negedge clk);
    endtask

    // channel a only: each character leaving toward the shifter, read mid-cycle once settled
    always @(negedge clk) begin
        if (got[0] === 1'b1)
            chk_byte("tx char", txq.size() ? txq.pop_front() : 8'hXX, got_data[0]);
    end

    // watchdog, far beyond the well under one thousand clocks the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end

    initial begin
        logic [7:0] d;
        int         k;
        {clk, rst_n, stall, send, cts, xoff, err, mchg, addr, wdata, chr} = '0;
        {rd_n, wr_n, cs_n, rx_line} = '1;
        void'($urandom(89));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        for (k = 0; k < 2; k++) rd_chk(k, A_IMASK, 8'h00);
        rd_chk(0, 3'h7, 8'h00);
        chk_bit("irq b", 1'b0, irq_b);
        chk_bit("read enable", 1'b0, oe);
        done("reset");
        // fill the transmit buffer past full while the shifter stalls
        stall[0] = 1'b1;
        for (k = 0; k < 3; k++) begin
            d = 8'($urandom);
            if (k < 2) txq.push_back(d);
            bus_wr(0, A_DATA, d);
        end
        chk_bit("tx space", 1'b0, space[0]);
        chk_bit("tx valid", 1'b1, tx_valid[0]);
        rd_chk(0, A_LSTAT, 8'h00);
        stall[0] = 1'b0;
        repeat (10) @(negedge clk);
        chk_bit("tx drained", 1'b1, txq.size() == 0);
        rd_chk(0, A_LSTAT, 8'h60);
        chk_bit("tx valid", 1'b0, tx_valid[0]);
        done("transmit");
        // three arrive, the third waits for room; reads come oldest first
        for (k = 0; k < 3; k++) begin
            d = 8'($urandom);
            rxq.push_back(d);
            send_rx(0, d);
        end
        chk_bit("rx ready", 1'b0, rx_ready[0]);
        for (k = 0; k < 3; k++) rd_chk(0, A_DATA, rxq.pop_front());
        chk_bit("rx avail", 1'b0, avail[0]);
        bus_wr(0, A_IMASK, 8'h01);
        send_rx(0, 8'h5A);
        chk_bit("irq a", 1'b1, irq_a);
        chk_bit("irq b", 1'b0, irq_b);
        rd_chk(0, A_IDENT, 8'h04);
        rd_chk(0, A_DATA, 8'h5A);
        chk_bit("irq a", 1'b0, irq_a);
        done("receive");
        // upper mask bits locked until enhanced mode is opened
        bus_wr(0, A_IMASK, 8'hF2);
        rd_chk(0, A_IMASK, 8'h02);
        chk_bit("sleep", 1'b0, sleep[0]);
        chk_bit("irq a", 1'b1, irq_a);
        rd_chk(0, A_IDENT, 8'h06);
        chk_bit("irq a", 1'b1, irq_a);
        bus_wr(0, A_LCR, ENH_KEY);
        bus_wr(0, A_IDENT, 8'h10);
        bus_wr(0, A_LCR, 8'h00);
        bus_wr(0, A_IMASK, 8'h10);
        chk_bit("sleep", 1'b1, sleep[0]);
        chk_bit("irq a", 1'b0, irq_a);
        done("mask");
        // each source: pending while masked, shown once enabled, then cleared
        for (k = 0; k < 5; k++) begin
            bus_wr(0, A_IMASK, 8'h00);
            fire(k);
            chk_bit("irq masked", 1'b0, irq_a);
            bus_wr(0, A_IMASK, ev_mask[k]);
            chk_bit("irq a", 1'b1, irq_a);
            chk_bit("irq b", 1'b0, irq_b);
            rd_chk(0, A_IDENT, ev_id[k]);
            if (k == 0) rd_chk(0, A_LSTAT, 8'hE4);
            if (k == 1) rd_chk(0, A_MSTAT, 8'h02);
            chk_bit("irq cleared", 1'b0, irq_a);
        end
        chk_bit("rts", 1'b1, rts[0]);
        // clear-to-send rising while its mask bit is already set
        cts[0] = 1'b0;
        repeat (4) @(negedge clk);
        cts[0] = 1'b1;
        repeat (4) @(negedge clk);
        chk_bit("irq cts", 1'b1, irq_a);
        rd_chk(0, A_IDENT, 8'h08);
        chk_bit("irq cleared", 1'b0, irq_a);
        done("sources");
        // buffered mode: transmit-empty is an event, receive uses trigger 2
        bus_wr(0, A_IDENT, 8'h41);
        bus_wr(0, A_IMASK, 8'h03);
        rd_chk(0, A_IDENT, 8'h09);
        chk_bit("irq a", 1'b0, irq_a);
        for (k = 0; k < 2; k++) begin
            stall[0] = k[0];
            d = 8'($urandom);
            txq.push_back(d);
            bus_wr(0, A_DATA, d);
            repeat (6) @(negedge clk);
            chk_bit("irq a", !k[0], irq_a);
        end
        stall[0] = 1'b0;
        repeat (6) @(negedge clk);
        rd_chk(0, A_IDENT, 8'h06);
        chk_bit("irq a", 1'b0, irq_a);
        bus_wr(0, A_IMASK, 8'h01);
        send_rx(0, 8'hA5);
        chk_bit("irq a", 1'b0, irq_a);
        send_rx(0, 8'h3C);
        chk_bit("irq a", 1'b1, irq_a);
        rd_chk(0, A_DATA, 8'hA5);
        chk_bit("irq a", 1'b0, irq_a);
        done("buffered");
        for (k = 0; k < 4; k++) start_try(k % 2, (k < 2) ? 31 : 6, k < 2);
        done("start");
        give_verdict();
    end
endmodule
